// >>> rtl/uart_channel_regs.sv
// UART channel register file with receive queue
`include "uart_regs.svh"

module rx_queue #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             one_deep,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("rx_queue: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic [AW:0]      cnt_nxt;
  logic             room_r;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;
  wire  [AW:0]      cap  = one_deep ? (AW+1)'(1) : (AW+1)'(DEPTH);

  // Ready is registered so the far side sees a clean level
  assign in_ready  = room_r;
  assign out_valid = cnt_r != '0;
  assign out_data  = mem[rp_r];
  assign level     = cnt_r;
  assign cnt_nxt   = flush ? '0 :
                     cnt_r + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk) begin
    if (push)
      mem[wp_r] <= in_data;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r   <= '0;
      rp_r   <= '0;
      cnt_r  <= '0;
      room_r <= 1'b0;
    end else begin
      wp_r   <= flush ? '0 : wp_r + AW'(push);
      rp_r   <= flush ? '0 : rp_r + AW'(pop);
      cnt_r  <= cnt_nxt;
      room_r <= cnt_nxt < cap;
    end
  end
endmodule : rx_queue

////////////////////////////////////////////////////////////////////////////////

module uart_channel_regs
  import uart_pkg::*;
#(
  parameter int DEPTH   = 32,
  parameter int TRIG_L0 = 1,
  parameter int TRIG_L1 = 8,
  parameter int TRIG_L2 = 16,
  parameter int TRIG_L3 = 28
) (
  input  wire logic     clk,
  input  wire logic     rst_n,
  input  wire reg_req_t reg_req,
  output logic [7:0]    reg_rdata,
  output logic          rx_char_ready,
  input  wire logic     rx_char_valid,
  input  wire rx_char_t rx_char,
  output logic          tx_char_valid,
  output logic [7:0]    tx_char,
  input  wire logic     tx_char_ready,
  input  wire logic     tx_shift_empty,
  input  wire logic     modem_pending,
  output logic          irq_n
);
  localparam int LW = $clog2(DEPTH) + 1;

  initial begin
    if (TRIG_L0 < 1 || TRIG_L3 > DEPTH || TRIG_L1 > DEPTH ||
        TRIG_L2 > DEPTH)
      $error("uart_channel_regs: trigger level outside queue depth");
    if (DEPTH < 2 || (1 << (LW - 1)) != DEPTH)
      $error("uart_channel_regs: DEPTH must be a power of two >= 2");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Stored registers
  logic [7:0] fmt_r, mask_r, modem_r, scratch_r;
  logic [7:0] div_lo_r, div_hi_r, div_frac_r, enh_r;
  logic [7:0] res1_r, res2_r, pau1_r, pau2_r;
  logic [7:0] gpio_lvl_r, gpio_msk_r, gpio_cfg_r, extra_r;
  logic       fifo_en_r;
  logic [1:0] rx_trig_r, tx_trig_r;
  logic       overrun_r;
  logic [LW-1:0] err_cnt_r;
  logic       tx_valid_r;
  logic [7:0] tx_data_r;
  logic [7:0] rdata_r;
  logic       irq_n_r;

  //////////////////////////////////////////////////////////////////////////////
  // Bank decode
  wire key_sel = fmt_r == `ENH_KEY;
  wire div_sel = fmt_r[`FMT_DIV_BIT] & !key_sel;
  wire unlock  = enh_r[`EFR_UNLOCK];
  wire wr      = reg_req.wr;
  wire rd      = reg_req.rd;
  wire [3:0] a = reg_req.addr;
  wire [7:0] wd = reg_req.wdata;

  wire a_data = a == `RA_DATA;
  wire a_mask = a == `RA_MASK;
  wire a_src  = a == `RA_SRC;
  wire a_b4   = a == `RA_MODEM;
  wire a_b5   = a == `RA_LSTAT;
  wire a_b6   = a == `RA_MSTAT;
  wire a_b7   = a == `RA_SCRATCH;
  wire std    = !div_sel & !key_sel;
  wire gpio_ok = !fmt_r[`FMT_DIV_BIT];

  wire w_thr   = wr & a_data & std;
  wire w_dll   = wr & a_data & div_sel;
  wire w_mask  = wr & a_mask & std;
  wire w_dlm   = wr & a_mask & div_sel;
  wire w_fcr   = wr & a_src & std;
  wire w_dld   = wr & a_src & div_sel & unlock;
  wire w_efr   = wr & a_src & key_sel;
  wire w_fmt   = wr & (a == `RA_FMT);
  wire w_modem = wr & a_b4 & !key_sel;
  wire w_res1  = wr & a_b4 & key_sel;
  wire w_res2  = wr & a_b5 & key_sel;
  wire w_pau1  = wr & a_b6 & key_sel;
  wire w_pau2  = wr & a_b7 & key_sel;
  wire w_scr   = wr & a_b7 & !key_sel;
  wire w_glvl  = wr & (a == `RA_GPIO_LVL) & gpio_ok;
  wire w_gmsk  = wr & (a == `RA_GPIO_MSK) & gpio_ok;
  wire w_gcfg  = wr & (a == `RA_GPIO_CFG);
  wire w_extra = wr & (a == `RA_EXTRA);
  wire r_rhr   = rd & a_data & std;
  wire r_lsr   = rd & a_b5 & !key_sel;

  // Other bits of the queue-control write only land with bit 0 set
  wire fcr_go  = w_fcr & wd[`FCR_EN];
  wire rx_flush = fcr_go & wd[`FCR_RX_RST];

  // Trigger select fields of the queue-control write
  wire [1:0] wd_rx_trig = wd[`FCR_RXT+1:`FCR_RXT];
  wire [1:0] wd_tx_trig = wd[`FCR_TXT+1:`FCR_TXT];

  //////////////////////////////////////////////////////////////////////////////
  // Receive queue
  rx_char_t      head;
  logic          head_valid;
  logic [LW-1:0] rx_level;
  wire           head_err = head.brk | head.frm | head.par;
  wire           in_err   = rx_char.brk | rx_char.frm | rx_char.par;
  wire           push     = rx_char_valid & rx_char_ready;
  // Reading an empty holding register shows stale data and pops nothing
  wire           pop      = r_rhr & head_valid;

  rx_queue #(
    .WIDTH ($bits(rx_char_t)),
    .DEPTH (DEPTH)
  ) u_rxq (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (rx_flush),
    .one_deep  (!fifo_en_r),
    .in_valid  (rx_char_valid),
    .in_ready  (rx_char_ready),
    .in_data   (rx_char),
    .out_valid (head_valid),
    .out_ready (pop),
    .out_data  (head),
    .level     (rx_level)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Line status
  wire [LW-1:0] trig = rx_trig_r == 2'd0 ? LW'(TRIG_L0) :
                       rx_trig_r == 2'd1 ? LW'(TRIG_L1) :
                       rx_trig_r == 2'd2 ? LW'(TRIG_L2) : LW'(TRIG_L3);
  // Receiver owns bits 0-4 and 7, transmitter bits 5 and 6
  wire lsr_dr   = head_valid;
  wire [2:0] lsr_err = head_valid ?
                       {head.brk, head.frm, head.par} : 3'b000;
  wire lsr_thre = !tx_valid_r;
  wire lsr_temt = !tx_valid_r & tx_shift_empty;
  wire lsr_gerr = err_cnt_r != '0;
  wire [7:0] line_status_reg = {lsr_gerr, lsr_temt, lsr_thre, lsr_err,
                    overrun_r, lsr_dr};
  wire err_in  = push & in_err & !rx_flush;
  wire err_out = pop & head_err & !rx_flush;

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt sources; all mask bits clear leaves only polling
  wire en_rx    = mask_r[`IER_RX];
  wire en_tx    = mask_r[`IER_TX];
  wire en_line  = mask_r[`IER_LINE];
  wire en_modem = mask_r[`IER_MODEM];

  wire rx_lvl  = fifo_en_r ? rx_level >= trig : head_valid;
  wire p_lstat = en_line & (overrun_r | (|lsr_err) | lsr_gerr);
  wire p_rx    = en_rx & rx_lvl;
  wire p_tx    = en_tx & lsr_thre;
  wire p_modem = en_modem & modem_pending;
  wire [5:0] src = p_lstat ? `SRC_LSTAT :
                   p_rx    ? `SRC_RXRDY :
                   p_tx    ? `SRC_TXRDY :
                   p_modem ? `SRC_MODEM : `SRC_NONE;
  wire [7:0] irq_source_reg = {fifo_en_r, fifo_en_r, src};

  //////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [7:0] rmux;
  always_comb begin
    rmux = `RST_BYTE;
    case (a)
      `RA_DATA:     rmux = div_sel ? div_lo_r : head.data;
      `RA_MASK:     rmux = div_sel ? div_hi_r : mask_r;
      `RA_SRC:      rmux = key_sel ? enh_r :
                           div_sel ? (unlock ? div_frac_r : `RST_BYTE) :
                           irq_source_reg;
      `RA_FMT:      rmux = fmt_r;
      `RA_MODEM:    rmux = key_sel ? res1_r : modem_r;
      `RA_LSTAT:    rmux = key_sel ? res2_r : line_status_reg;
      `RA_MSTAT:    rmux = key_sel ? pau1_r : `RST_BYTE;
      `RA_SCRATCH:  rmux = key_sel ? pau2_r : scratch_r;
      `RA_GPIO_LVL: rmux = gpio_ok ? gpio_lvl_r : `RST_BYTE;
      `RA_GPIO_MSK: rmux = gpio_ok ? gpio_msk_r : `RST_BYTE;
      `RA_RSVD:     rmux = `RST_BYTE;
      `RA_GPIO_CFG: rmux = gpio_cfg_r;
      `RA_EXTRA:    rmux = extra_r;
      default:      rmux = `RST_BYTE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next values with lock masking
  // Upper mask and modem bits stay locked until enhanced bit 4 is set
  wire [7:0] mask_nxt  = unlock ? wd : {mask_r[7:4], wd[3:0]};
  wire [7:0] modem_nxt = unlock ? wd : {modem_r[7:5], wd[4:0]};
  wire [1:0] tx_trig_nxt = unlock ? wd_tx_trig : tx_trig_r;
  // A loss in the clearing cycle keeps overrun set
  wire       ovr_nxt = (rx_char_valid & !rx_char_ready) |
                       (overrun_r & !r_lsr);
  wire [LW-1:0] err_nxt = rx_flush ? '0 :
                          err_cnt_r + LW'(err_in) - LW'(err_out);
  wire       txv_nxt = w_thr | (tx_valid_r & !tx_char_ready);

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fmt_r      <= `RST_FMT;
      mask_r     <= `RST_BYTE;
      modem_r    <= `RST_BYTE;
      scratch_r  <= `RST_BYTE;
      div_lo_r   <= `RST_BYTE;
      div_hi_r   <= `RST_BYTE;
      div_frac_r <= `RST_BYTE;
      enh_r      <= `RST_BYTE;
      res1_r     <= `RST_BYTE;
      res2_r     <= `RST_BYTE;
      pau1_r     <= `RST_BYTE;
      pau2_r     <= `RST_BYTE;
    end else begin
      if (w_fmt)   fmt_r      <= wd;
      if (w_mask)  mask_r     <= mask_nxt;
      if (w_modem) modem_r    <= modem_nxt;
      if (w_scr)   scratch_r  <= wd;
      if (w_dll)   div_lo_r   <= wd;
      if (w_dlm)   div_hi_r   <= wd;
      if (w_dld)   div_frac_r <= wd;
      if (w_efr)   enh_r      <= wd;
      if (w_res1)  res1_r     <= wd;
      if (w_res2)  res2_r     <= wd;
      if (w_pau1)  pau1_r     <= wd;
      if (w_pau2)  pau2_r     <= wd;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_lvl_r <= `RST_BYTE;
      gpio_msk_r <= `RST_BYTE;
      gpio_cfg_r <= `RST_BYTE;
      extra_r    <= `RST_BYTE;
      fifo_en_r  <= 1'b0;
      rx_trig_r  <= 2'b00;
      tx_trig_r  <= 2'b00;
    end else begin
      if (w_glvl)  gpio_lvl_r <= wd;
      if (w_gmsk)  gpio_msk_r <= wd;
      if (w_gcfg)  gpio_cfg_r <= {4'h0, wd[3:0]};
      if (w_extra) extra_r    <= {wd[7], 1'b0, wd[5:4], 1'b0, wd[2:0]};
      if (w_fcr)   fifo_en_r  <= wd[`FCR_EN];
      if (fcr_go)  rx_trig_r  <= wd_rx_trig;
      if (fcr_go)  tx_trig_r  <= tx_trig_nxt;
    end
  end

  // Flags set by hardware win over the clearing read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_r  <= 1'b0;
      err_cnt_r  <= '0;
      tx_valid_r <= 1'b0;
      tx_data_r  <= `RST_BYTE;
      rdata_r    <= `RST_BYTE;
      irq_n_r    <= 1'b1;
    end else begin
      overrun_r  <= ovr_nxt;
      err_cnt_r  <= err_nxt;
      tx_valid_r <= txv_nxt;
      if (w_thr)   tx_data_r <= wd;
      if (rd)      rdata_r   <= rmux;
      // Interrupt output lags its cause by one cycle
      irq_n_r    <= src == `SRC_NONE;
    end
  end

  assign reg_rdata     = rdata_r;
  assign tx_char_valid = tx_valid_r;
  assign tx_char       = tx_data_r;
  assign irq_n         = irq_n_r;
endmodule : uart_channel_regs

// >>> shared/uart_regs.svh
// Register offsets, field positions and reset values of one UART channel
`ifndef UART_CH_REGS_SVH
`define UART_CH_REGS_SVH
`define RA_DATA      4'h0
`define RA_MASK      4'h1
`define RA_SRC       4'h2
`define RA_FMT       4'h3
`define RA_MODEM     4'h4
`define RA_LSTAT     4'h5
`define RA_MSTAT     4'h6
`define RA_SCRATCH   4'h7
`define RA_GPIO_LVL  4'hB
`define RA_GPIO_MSK  4'hC
`define RA_RSVD      4'hD
`define RA_GPIO_CFG  4'hE
`define RA_EXTRA     4'hF
`define ENH_KEY      8'hBF
`define FMT_DIV_BIT  7
`define EFR_UNLOCK   4
`define FCR_EN       0
`define FCR_RX_RST   1
`define FCR_TXT      4
`define FCR_RXT      6
`define IER_RX       0
`define IER_TX       1
`define IER_LINE     2
`define IER_MODEM    3
`define SRC_LSTAT    6'h06
`define SRC_RXRDY    6'h04
`define SRC_TXRDY    6'h02
`define SRC_MODEM    6'h00
`define SRC_NONE     6'h01
`define RST_BYTE     8'h00
`define RST_FMT      8'h03
`endif

// >>> shared/uart_pkg.sv
// Types shared by the UART channel register block
package uart_pkg;
  typedef struct packed {
    logic       brk;
    logic       frm;
    logic       par;
    logic [7:0] data;
  } rx_char_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage : uart_pkg

// >>> verification/uart_channel_regs_sva.sv
// Port checker of the UART channel register block
module uart_channel_regs_sva
  import uart_pkg::*;
#(
  parameter int DEPTH   = 32,
  parameter int TRIG_L0 = 1,
  parameter int TRIG_L1 = 8,
  parameter int TRIG_L2 = 16,
  parameter int TRIG_L3 = 28
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire reg_req_t   reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic       rx_char_ready,
  input wire logic       rx_char_valid,
  input wire rx_char_t   rx_char,
  input wire logic       tx_char_valid,
  input wire logic [7:0] tx_char,
  input wire logic       tx_char_ready,
  input wire logic       tx_shift_empty,
  input wire logic       modem_pending,
  input wire logic       irq_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] fmt_r;
  logic [3:0] mask_r;
  logic [1:0] trig_r;
  logic [6:0] cnt_r;
  logic       fen_r;
  logic       ovr_r;
  int         trig_lvl;
  // Shadow of the state the host can infer from its own accesses
  wire nrm    = !fmt_r[7];
  wire lo_nrm = nrm;
  wire wr0    = reg_req.wr && reg_req.addr == 4'h0 && lo_nrm;
  wire push   = rx_char_valid && rx_char_ready;
  wire pop    = reg_req.rd && reg_req.addr == 4'h0 && lo_nrm && |cnt_r;
  wire lsr_rd = reg_req.rd && reg_req.addr == 4'h5 && fmt_r != 8'hBF;
  wire qc_wr  = reg_req.wr && reg_req.addr == 4'h2 && nrm;
  wire flush  = qc_wr && reg_req.wdata[0] && reg_req.wdata[1];
  assign trig_lvl = trig_r == 2'h0 ? TRIG_L0 : trig_r == 2'h1 ? TRIG_L1 :
                    trig_r == 2'h2 ? TRIG_L2 : TRIG_L3;
  wire rx_cond = fen_r ? int'(cnt_r) >= trig_lvl : |cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fmt_r  <= 8'h03;
      mask_r <= 4'h0;
      trig_r <= 2'h0;
      fen_r  <= 1'b0;
      ovr_r  <= 1'b0;
      cnt_r  <= 7'h00;
    end else begin
      if (reg_req.wr && reg_req.addr == 4'h3) fmt_r <= reg_req.wdata;
      if (reg_req.wr && reg_req.addr == 4'h1 && lo_nrm)
        mask_r <= reg_req.wdata[3:0];
      if (qc_wr) fen_r <= reg_req.wdata[0];
      if (qc_wr && reg_req.wdata[0]) trig_r <= reg_req.wdata[7:6];
      ovr_r <= (rx_char_valid && !rx_char_ready) || (ovr_r && !lsr_rd);
      cnt_r <= flush ? 7'h00 : cnt_r + 7'(push) - 7'(pop);
    end
  end

  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  tx_load_a: assert property (wr0 |=> tx_char_valid &&
    tx_char == $past(reg_req.wdata)) else $error("tx holding not loaded");
  tx_hold_a: assert property (tx_char_valid && !tx_char_ready && !wr0
    |=> tx_char_valid && $stable(tx_char)) else $error("tx char lost");
  rsvd_zero_a: assert property (reg_req.rd && reg_req.addr == 4'hD
    && nrm |=> reg_rdata == 8'h00) else $error("reserved not zero");
  rx_ready_a: assert property (lsr_rd |=>
    reg_rdata[0] == ($past(cnt_r) != 7'h00)) else $error("data ready wrong");
  tx_empty_a: assert property (lsr_rd |=>
    reg_rdata[5] == !$past(tx_char_valid)) else $error("tx empty wrong");
  all_sent_a: assert property (lsr_rd |=> reg_rdata[6] ==
    (!$past(tx_char_valid) && $past(tx_shift_empty)))
    else $error("all sent flag wrong");
  overrun_a: assert property (lsr_rd && ovr_r |=> reg_rdata[1])
    else $error("overrun not shown");
  polled_quiet_a: assert property ($past(mask_r) == 4'h0 |-> irq_n)
    else $error("irq in polled mode");
  rx_irq_a: assert property ($past(mask_r) == 4'h1 |->
    irq_n == !$past(rx_cond)) else $error("rx irq wrong");
  tx_irq_a: assert property ($past(mask_r) == 4'h2 |->
    irq_n == $past(tx_char_valid)) else $error("tx irq wrong");

  cover property (wr0 ##1 tx_char_valid && tx_char_ready);
  cover property (rx_char_valid && !rx_char_ready);
  cover property (!irq_n && fen_r);
  cover property (modem_pending && !irq_n);
endmodule : uart_channel_regs_sva

bind uart_channel_regs uart_channel_regs_sva #(.DEPTH(DEPTH),
  .TRIG_L0(TRIG_L0), .TRIG_L1(TRIG_L1), .TRIG_L2(TRIG_L2),
  .TRIG_L3(TRIG_L3)) u_uart_channel_regs_sva (.clk(clk), .rst_n(rst_n),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .rx_char_ready(rx_char_ready),
  .rx_char_valid(rx_char_valid), .rx_char(rx_char),
  .tx_char_valid(tx_char_valid), .tx_char(tx_char),
  .tx_char_ready(tx_char_ready), .tx_shift_empty(tx_shift_empty),
  .modem_pending(modem_pending), .irq_n(irq_n));

// >>> verification/far_uart_model.sv
// Remote UART model: delivers received chars, drains the tx holding register
module far_uart_model
  import uart_pkg::*;
#(
  parameter int SHIFT_CYC = 6
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       send,
  input  wire rx_char_t   send_char,
  input  wire logic       stall,
  input  wire logic       tx_char_valid,
  input  wire logic [7:0] tx_char,
  output logic            rx_char_valid,
  output rx_char_t        rx_char,
  output logic            tx_char_ready,
  output logic            tx_shift_empty,
  output logic [7:0]      got_char
);
  timeunit 1ns;
  timeprecision 1ns;
  int shift_cnt;
  assign tx_char_ready  = !stall && shift_cnt == 0;
  assign tx_shift_empty = shift_cnt == 0;

  // A received char is offered for one cycle only, as a real line cannot wait
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_char_valid <= 1'b0;
      rx_char       <= '0;
      shift_cnt     <= 0;
      got_char      <= 8'h00;
    end else begin
      rx_char_valid <= send;
      rx_char       <= send ? send_char : ~rx_char;
      if (tx_char_valid && tx_char_ready) begin
        got_char  <= tx_char;
        shift_cnt <= SHIFT_CYC;
      end else if (shift_cnt != 0) begin
        shift_cnt <= shift_cnt - 1;
      end
    end
  end
endmodule : far_uart_model

// >>> verification/tb_uart_channel_regs.sv
// Self-checking bench of the UART channel register block
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
  error_cnt++; $display("unexpected at %0t: got %h exp %h", $time, got, \
  exp); end end

module tb_uart_channel_regs
  import uart_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rst_n, rx_char_ready, rx_char_valid, tx_char_valid;
  logic       tx_char_ready, tx_shift_empty, irq_n, send, stall;
  logic       modem_pending;
  logic [7:0] reg_rdata, tx_char, got_char, rv;
  reg_req_t   reg_req;
  rx_char_t   rx_char, send_char;
  int         error_cnt, num_checks, cyc, i;

  uart_channel_regs #(.DEPTH(32), .TRIG_L0(1), .TRIG_L1(8), .TRIG_L2(16),
    .TRIG_L3(28)) u_uart_channel_regs (.clk(clk), .rst_n(rst_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata),
    .rx_char_ready(rx_char_ready), .rx_char_valid(rx_char_valid),
    .rx_char(rx_char), .tx_char_valid(tx_char_valid), .tx_char(tx_char),
    .tx_char_ready(tx_char_ready), .tx_shift_empty(tx_shift_empty),
    .modem_pending(modem_pending), .irq_n(irq_n));
  far_uart_model u_far_uart_model (.clk(clk),
    .rst_n(rst_n), .send(send), .send_char(send_char), .stall(stall),
    .tx_char_valid(tx_char_valid), .tx_char(tx_char),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .tx_char_ready(tx_char_ready), .tx_shift_empty(tx_shift_empty),
    .got_char(got_char));

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  task automatic acc(input logic w, input logic [3:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    reg_req <= '0;
    @(negedge clk);
    rv = reg_rdata;
  endtask : acc

  task automatic rchk(input logic [3:0] a, input logic [7:0] e,
                      input logic [7:0] m = 8'hFF);
    acc(1'b0, a, 8'h00);
    `CHK(rv & m, e)
  endtask : rchk

  task automatic push(input rx_char_t c);
    @(posedge clk);
    send      <= 1'b1;
    send_char <= c;
    @(posedge clk);
    send <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : push

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      test_done();
    end
  end

  //////////////////////////////////////////////////////////////////////
  initial begin
    rst_n         = 1'b0;
    reg_req       = '0;
    send          = 1'b0;
    send_char     = '0;
    stall         = 1'b0;
    modem_pending = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rchk(4'h3, 8'h03);
    rchk(4'h1, 8'h00);
    rchk(4'h5, 8'h60);
    rchk(4'h2, 8'h01);
    acc(1'b1, 4'hD, 8'hFF);
    rchk(4'hD, 8'h00);
    // Transmit while the far side stalls
    @(posedge clk);
    stall <= 1'b1;
    acc(1'b1, 4'h0, 8'hA5);
    `CHK(tx_char, 8'hA5)
    rchk(4'h5, 8'h00, 8'h60);
    @(posedge clk);
    stall <= 1'b0;
    repeat (12) @(posedge clk);
    `CHK(got_char, 8'hA5)
    rchk(4'h5, 8'h60);
    // Single holding register, then a lost char
    acc(1'b1, 4'h1, 8'hF1);
    rchk(4'h1, 8'h01);
    push('{brk: 1'b0, frm: 1'b0, par: 1'b0, data: 8'h3C});
    `CHK(irq_n, 1'b0)
    rchk(4'h5, 8'h61);
    push('{brk: 1'b0, frm: 1'b0, par: 1'b0, data: 8'hC3});
    rchk(4'h5, 8'h63);
    rchk(4'h0, 8'h3C);
    rchk(4'h5, 8'h60);
    // Queue mode, trigger select 1, filled to refusal
    acc(1'b1, 4'h2, 8'h41);
    rchk(4'h2, 8'hC1);
    for (i = 0; i < 32; i++) begin
      push('{brk: i == 5, frm: i == 4, par: i == 2, data: 8'h40 + 8'(i)});
      `CHK(irq_n, logic'(i < 7))
    end
    `CHK(rx_char_ready, 1'b0)
    rchk(4'h2, 8'hC4);
    acc(1'b1, 4'h1, 8'h00);
    repeat (2) @(negedge clk);
    `CHK(irq_n, 1'b1)
    rchk(4'h5, 8'hE1);
    acc(1'b1, 4'h1, 8'h01);
    for (i = 0; i < 32; i++) begin
      rchk(4'h5, {i <= 5, 2'b11, i == 5, i == 4, i == 2, 2'b01});
      rchk(4'h0, 8'h40 + 8'(i));
      repeat (2) @(negedge clk);
      `CHK(irq_n, logic'(31 - i < 8))
    end
    rchk(4'h5, 8'h60);
    rchk(4'h2, 8'hC1);
    // Transmit-empty source
    @(posedge clk);
    stall <= 1'b1;
    acc(1'b1, 4'h1, 8'h02);
    rchk(4'h2, 8'hC2);
    acc(1'b1, 4'h0, 8'h5A);
    repeat (2) @(negedge clk);
    `CHK(irq_n, 1'b1)
    @(posedge clk);
    stall <= 1'b0;
    // Register banks selected by the line format value
    acc(1'b1, 4'h3, 8'h80);
    acc(1'b1, 4'h0, 8'h12);
    acc(1'b1, 4'h1, 8'h34);
    acc(1'b1, 4'h2, 8'h56);
    rchk(4'h2, 8'h00);
    acc(1'b1, 4'h3, 8'hBF);
    acc(1'b1, 4'h2, 8'h10);
    for (i = 4; i < 8; i++)
      acc(1'b1, 4'(i), 8'h10 + 8'(i));
    for (i = 4; i < 8; i++)
      rchk(4'(i), 8'h10 + 8'(i));
    rchk(4'h2, 8'h10);
    acc(1'b1, 4'h3, 8'h80);
    rchk(4'h0, 8'h12);
    rchk(4'h1, 8'h34);
    acc(1'b1, 4'h2, 8'h56);
    rchk(4'h2, 8'h56);
    acc(1'b1, 4'h3, 8'h03);
    acc(1'b1, 4'h1, 8'hF1);
    rchk(4'h1, 8'hF1);
    // Modem source alone
    acc(1'b1, 4'h1, 8'h08);
    rchk(4'h2, 8'hC1);
    @(posedge clk);
    modem_pending <= 1'b1;
    repeat (2) @(negedge clk);
    `CHK(irq_n, 1'b0)
    rchk(4'h2, 8'hC0);
    @(posedge clk);
    modem_pending <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK(irq_n, 1'b1)
    test_done();
  end
endmodule : tb_uart_channel_regs
